// ==== src/ilo_core.sv ====
// Top of the indexed literal offset decoder: register port, phase
// sequencer, operand addressing and write-back.
// Assumes data memory on the same clock answering a read one cycle later.
`timescale 1ns/1ps
module ilo_core
  import ilo_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire logic           rst,
  input  wire logic [RAW-1:0] reg_addr,
  input  wire logic [RDW-1:0] reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic      [RDW-1:0] reg_rdata,
  output logic      [MAW-1:0] mem_addr,
  output logic                mem_rd,
  output logic                mem_wr,
  output logic      [7:0]     mem_wdata,
  input  wire logic [7:0]     mem_rdata,
  output logic                busy
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ilo_state_t     state_ff;
  ilo_state_t     nxt_state;
  logic           ext_en_ff;
  logic           nxt_ext_en;
  logic [MAW-1:0] ptr2_ff;
  logic [MAW-1:0] nxt_ptr2;
  logic [3:0]     bank_ff;
  logic [3:0]     nxt_bank;
  logic [7:0]     work_ff;
  logic [7:0]     nxt_work;
  logic [4:0]     flags_ff;
  logic [4:0]     nxt_flags;
  logic           unsup_ff;
  logic           nxt_unsup;
  logic [15:0]    instr_ff;
  logic [15:0]    nxt_instr;
  ilo_op_t        op_ff;
  ilo_op_t        nxt_op;
  logic [MAW-1:0] addr_ff;
  logic [MAW-1:0] nxt_addr;
  logic           indexed_ff;
  logic           nxt_indexed;
  logic           to_file_ff;
  logic           nxt_to_file;
  logic           to_work_ff;
  logic           nxt_to_work;
  logic [7:0]     wdata_ff;
  logic [7:0]     nxt_wdata;
  logic [4:0]     pflags_ff;
  logic [4:0]     nxt_pflags;
  logic [4:0]     pmask_ff;
  logic [4:0]     nxt_pmask;
  logic [RDW-1:0] rdata_ff;
  logic [RDW-1:0] nxt_rdata;

  // ----------------------------------------------------------------
  // Combinational helpers
  // ----------------------------------------------------------------
  logic [MAW-1:0] gen_addr;
  logic           gen_indexed;
  ilo_op_t        dec_op;
  logic           has_dest;
  logic [7:0]     alu_result;
  logic [4:0]     alu_flags;
  logic [4:0]     alu_mask;
  logic           start;
  logic [7:0]     status_view;
  logic           wr_ctrl;
  logic           wr_ptr2;
  logic           wr_bank;
  logic           wr_work;
  logic           wr_status;
  logic           wr_instr;

  // ----------------------------------------------------------------
  // Operand addressing and data path
  // ----------------------------------------------------------------
  // Every byte and bit opcode goes through the same generator
  ilo_addr_gen u_addr_gen (
    .ext_en   (ext_en_ff),
    .acc_sel  (instr_ff[IN_ACCESS_BIT]),
    .f_field  (instr_ff[7:0]),
    .ptr_two  (ptr2_ff),
    .bank_sel (bank_ff),
    .eff_addr (gen_addr),
    .indexed  (gen_indexed)
  );

  // Byte path takes read data straight off the memory port
  ilo_alu u_alu (
    .op        (op_ff),
    .work      (work_ff),
    .operand   (mem_rdata),
    .bit_sel   (instr_ff[IN_BIT_LSB +: 3]),
    .result    (alu_result),
    .flags     (alu_flags),
    .flag_mask (alu_mask)
  );

  // Decode of the held opcode
  assign dec_op   = ilo_decode(instr_ff);
  assign has_dest = (dec_op == OP_ADD) || (dec_op == OP_MOVF);
  // A new opcode is refused while one is in flight
  assign start    = wr_instr && (state_ff == ST_IDLE);

  // ----------------------------------------------------------------
  // Register write decode, shared by software and collision logic
  // ----------------------------------------------------------------
  assign wr_ctrl   = reg_wr && (reg_addr == REG_CTRL);
  assign wr_ptr2   = reg_wr && (reg_addr == REG_PTR2);
  assign wr_bank   = reg_wr && (reg_addr == REG_BANK);
  assign wr_work   = reg_wr && (reg_addr == REG_WORK);
  assign wr_status = reg_wr && (reg_addr == REG_STATUS);
  assign wr_instr  = reg_wr && (reg_addr == REG_INSTR);

  // ----------------------------------------------------------------
  // Port outputs
  // ----------------------------------------------------------------
  assign busy      = (state_ff != ST_IDLE);
  assign mem_rd    = (state_ff == ST_READ);
  assign mem_wr    = (state_ff == ST_WRITE) && to_file_ff;
  assign mem_addr  = addr_ff;
  assign mem_wdata = wdata_ff;
  assign reg_rdata = rdata_ff;
  // Status byte: busy, sticky unsupported, spare, flags
  assign status_view = {busy, unsup_ff, 1'b0, flags_ff};

  // ----------------------------------------------------------------
  // Phase sequencer: one instruction cycle as four phases
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:   if (start) nxt_state = ST_DECODE;
      ST_DECODE: nxt_state = ST_READ;
      ST_READ:   nxt_state = ST_PROC;
      ST_PROC:   nxt_state = ST_WRITE;
      ST_WRITE:  nxt_state = ST_IDLE;
      default:   nxt_state = ST_IDLE;
    endcase
  end

  // Phase register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Execution state: latched per phase
  // ----------------------------------------------------------------
  always_comb begin
    nxt_instr   = instr_ff;
    nxt_op      = op_ff;
    nxt_addr    = addr_ff;
    nxt_indexed = indexed_ff;
    nxt_to_file = to_file_ff;
    nxt_to_work = to_work_ff;
    nxt_wdata   = wdata_ff;
    nxt_pflags  = pflags_ff;
    nxt_pmask   = pmask_ff;
    if (start) begin
      nxt_instr = reg_wdata;
    end
    if (state_ff == ST_DECODE) begin
      // Address is complete before the read phase
      nxt_op      = dec_op;
      nxt_addr    = gen_addr;
      nxt_indexed = gen_indexed;
      // Destination bit keeps its plain meaning in both modes
      nxt_to_file = has_dest ? instr_ff[IN_DEST_BIT] : (dec_op != OP_NONE);
      nxt_to_work = has_dest && !instr_ff[IN_DEST_BIT];
    end
    if (state_ff == ST_PROC) begin
      // Read data arrive in this phase
      nxt_wdata  = alu_result;
      nxt_pflags = alu_flags;
      nxt_pmask  = alu_mask;
    end
  end

  // Execution registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      instr_ff   <= '0;
      op_ff      <= OP_NONE;
      addr_ff    <= '0;
      indexed_ff <= 1'b0;
      to_file_ff <= 1'b0;
      to_work_ff <= 1'b0;
      wdata_ff   <= '0;
      pflags_ff  <= '0;
      pmask_ff   <= '0;
    end else begin
      instr_ff   <= nxt_instr;
      op_ff      <= nxt_op;
      addr_ff    <= nxt_addr;
      indexed_ff <= nxt_indexed;
      to_file_ff <= nxt_to_file;
      to_work_ff <= nxt_to_work;
      wdata_ff   <= nxt_wdata;
      pflags_ff  <= nxt_pflags;
      pmask_ff   <= nxt_pmask;
    end
  end

  // ----------------------------------------------------------------
  // Software registers; hardware write-back wins a same-cycle write
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ext_en = ext_en_ff;
    nxt_ptr2   = ptr2_ff;
    nxt_bank   = bank_ff;
    nxt_work   = work_ff;
    nxt_flags  = flags_ff;
    nxt_unsup  = unsup_ff;
    // Each index except REG_EADDR has its own decoded strobe
    if (wr_ctrl) begin
      nxt_ext_en = reg_wdata[CTRL_EXT_BIT];
    end
    if (wr_ptr2) begin
      nxt_ptr2 = reg_wdata[MAW-1:0];
    end
    if (wr_bank) begin
      nxt_bank = reg_wdata[3:0];
    end
    if (wr_work) begin
      nxt_work = reg_wdata[7:0];
    end
    if (wr_status) begin
      nxt_flags = reg_wdata[4:0];
      nxt_unsup = reg_wdata[ST_UNSUP_BIT];
    end
    if (state_ff == ST_WRITE) begin
      if (to_work_ff) begin
        nxt_work = wdata_ff;
      end
      // Only flags the operation owns are touched
      nxt_flags = (flags_ff & ~pmask_ff) | (pflags_ff & pmask_ff);
      if (wr_status) begin
        nxt_flags = (reg_wdata[4:0] & ~pmask_ff) | (pflags_ff & pmask_ff);
      end
      if (op_ff == OP_NONE) begin
        nxt_unsup = 1'b1;
      end
    end
  end

  // Software-visible registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_en_ff <= 1'b0;
      ptr2_ff   <= '0;
      bank_ff   <= '0;
      work_ff   <= '0;
      flags_ff  <= '0;
      unsup_ff  <= 1'b0;
    end else begin
      ext_en_ff <= nxt_ext_en;
      ptr2_ff   <= nxt_ptr2;
      bank_ff   <= nxt_bank;
      work_ff   <= nxt_work;
      flags_ff  <= nxt_flags;
      unsup_ff  <= nxt_unsup;
    end
  end

  // ----------------------------------------------------------------
  // Read port: data valid only in the cycle after the strobe
  // ----------------------------------------------------------------
  // Unmapped indices and idle cycles read as zero
  always_comb begin
    nxt_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:   nxt_rdata = {15'h0000, ext_en_ff};
        REG_PTR2:   nxt_rdata = {4'h0, ptr2_ff};
        REG_BANK:   nxt_rdata = {12'h000, bank_ff};
        REG_WORK:   nxt_rdata = {8'h00, work_ff};
        REG_STATUS: nxt_rdata = {8'h00, status_view};
        REG_INSTR:  nxt_rdata = instr_ff;
        REG_EADDR:  nxt_rdata = {indexed_ff, 3'h0, addr_ff};
        default:    nxt_rdata = '0;
      endcase
    end
  end

  // Read data register, cleared between reads
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

endmodule : ilo_core

// ==== pkg/ilo_pkg.sv ====
// Constants, types and decode helpers for the indexed literal offset decoder.
// Assumes a single core clock and a plain same-clock register port.
// How it works
// - Extension enable turns indexed literal offset addressing on; disabled means off.
// - Extension off: operand is a literal, access bank or bank-selected page.
// - Extension on, access bit clear, operand 5Fh or less: pointer two plus offset.
// - Operands above 5Fh keep their literal meaning even with extension on.
// - Same substitution for every byte and bit instruction with access bit.
// - Pointer two at 00h makes offsets reach the original access RAM.
// - Indexed form always has its access bit at 0.
// - Destination bit picks working register or data location as usual.
// - Indexed add: working plus byte at pointer plus k, updates five flags.
// - Add result to working when destination 0, back to memory when 1.
package ilo_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int RAW = 4;   // register port address
  localparam int RDW = 16;  // register port data
  localparam int MAW = 12;  // data memory address

  // ----------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [RAW-1:0] REG_CTRL   = 4'h0;
  localparam logic [RAW-1:0] REG_PTR2   = 4'h1;
  localparam logic [RAW-1:0] REG_BANK   = 4'h2;
  localparam logic [RAW-1:0] REG_WORK   = 4'h3;
  localparam logic [RAW-1:0] REG_STATUS = 4'h4;
  localparam logic [RAW-1:0] REG_INSTR  = 4'h5;
  localparam logic [RAW-1:0] REG_EADDR  = 4'h6;

  localparam int CTRL_EXT_BIT       = 0;
  localparam int ST_CARRY_BIT       = 0;
  localparam int ST_DIGIT_CARRY_BIT = 1;
  localparam int ST_ZERO_BIT        = 2;
  localparam int ST_OVERFLOW_BIT    = 3;
  localparam int ST_NEG_BIT         = 4;
  localparam int ST_UNSUP_BIT       = 6;
  localparam int ST_BUSY_BIT        = 7;
  localparam int EADDR_INDEXED_BIT  = 15;

  // ----------------------------------------------------------------
  // Instruction fields and encodings
  // ----------------------------------------------------------------
  localparam int IN_ACCESS_BIT = 8;
  localparam int IN_DEST_BIT   = 9;
  localparam int IN_BIT_LSB    = 9;

  localparam logic [5:0] OPC_ADD_WORKING_TO_FILE = 6'h09; // [15:10]
  localparam logic [5:0] OPC_MOVE_FILE           = 6'h14; // [15:10]
  localparam logic [6:0] OPC_MOVE_WORKING        = 7'h37; // [15:9]
  localparam logic [6:0] OPC_CLEAR_FILE          = 7'h35; // [15:9]
  localparam logic [6:0] OPC_SET_FILE            = 7'h34; // [15:9]
  localparam logic [3:0] OPC_BIT_SET             = 4'h8;  // [15:12]
  localparam logic [3:0] OPC_BIT_CLEAR           = 4'h9;  // [15:12]

  // ----------------------------------------------------------------
  // Addressing constants and byte constants
  // ----------------------------------------------------------------
  localparam logic [7:0] ACCESS_LIMIT   = 8'h5f;
  localparam logic [3:0] ACCESS_HI_PAGE = 4'hf;
  localparam logic [3:0] ACCESS_LO_PAGE = 4'h0;
  localparam logic [7:0] BYTE_ONE       = 8'h01;
  localparam logic [7:0] BYTE_ALL       = 8'hff;

  typedef enum logic [2:0] {
    OP_NONE, OP_ADD, OP_MOVF, OP_MOVWF, OP_CLRF, OP_SETF, OP_BSF, OP_BCF
  } ilo_op_t;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_DECODE = 5'h02,
    ST_READ   = 5'h04,
    ST_PROC   = 5'h08,
    ST_WRITE  = 5'h10
  } ilo_state_t;

  // Opcode to operation
  function automatic ilo_op_t ilo_decode(input logic [15:0] ins);
    ilo_op_t op;
    op = OP_NONE;
    if (ins[15:10] == OPC_ADD_WORKING_TO_FILE) op = OP_ADD;
    else if (ins[15:10] == OPC_MOVE_FILE) op = OP_MOVF;
    else if (ins[15:9] == OPC_MOVE_WORKING) op = OP_MOVWF;
    else if (ins[15:9] == OPC_CLEAR_FILE) op = OP_CLRF;
    else if (ins[15:9] == OPC_SET_FILE) op = OP_SETF;
    else if (ins[15:12] == OPC_BIT_SET) op = OP_BSF;
    else if (ins[15:12] == OPC_BIT_CLEAR) op = OP_BCF;
    return op;
  endfunction : ilo_decode

endpackage : ilo_pkg

// ==== src/ilo_addr_gen.sv ====
// Effective data address generator for file operands.
// Assumes all inputs are stable in the decode phase.
`timescale 1ns/1ps
module ilo_addr_gen
  import ilo_pkg::*;
(
  input  wire logic           ext_en,
  input  wire logic           acc_sel,
  input  wire logic [7:0]     f_field,
  input  wire logic [MAW-1:0] ptr_two,
  input  wire logic [3:0]     bank_sel,
  output logic      [MAW-1:0] eff_addr,
  output logic                indexed
);

  logic low_half;

  // ----------------------------------------------------------------
  // Mode select and address mux
  // ----------------------------------------------------------------
  assign low_half = (f_field <= ACCESS_LIMIT);
  // Only an access-bit-clear operand can be indexed
  assign indexed  = ext_en && !acc_sel && low_half;

  // Sum wraps at full width; bank select deliberately ignored here
  always_comb begin
    if (indexed) begin
      eff_addr = MAW'(ptr_two + {ACCESS_LO_PAGE, f_field});
    end else if (acc_sel) begin
      eff_addr = {bank_sel, f_field};
    end else if (low_half) begin
      eff_addr = {ACCESS_LO_PAGE, f_field};
    end else begin
      eff_addr = {ACCESS_HI_PAGE, f_field};
    end
  end

endmodule : ilo_addr_gen

// ==== src/ilo_alu.sv ====
// Byte data path for the supported byte and bit operations.
// Assumes operand and working value are valid together in the process phase.
`timescale 1ns/1ps
module ilo_alu
  import ilo_pkg::*;
(
  input  wire ilo_op_t    op,
  input  wire logic [7:0] work,
  input  wire logic [7:0] operand,
  input  wire logic [2:0] bit_sel,
  output logic      [7:0] result,
  output logic      [4:0] flags,
  output logic      [4:0] flag_mask
);

  logic [8:0] sum;
  logic [4:0] half;
  logic [7:0] bmask;

  assign sum   = {1'b0, work} + {1'b0, operand};
  assign half  = {1'b0, work[3:0]} + {1'b0, operand[3:0]};
  assign bmask = BYTE_ONE << bit_sel;

  // ----------------------------------------------------------------
  // Operation select
  // ----------------------------------------------------------------
  always_comb begin
    result    = operand;
    flags     = '0;
    flag_mask = '0;
    case (op)
      OP_ADD: begin
        result                      = sum[7:0];
        flags[ST_CARRY_BIT]         = sum[8];
        flags[ST_DIGIT_CARRY_BIT]   = half[4];
        flags[ST_ZERO_BIT]          = (sum[7:0] == 8'h00);
        flags[ST_OVERFLOW_BIT]      = (work[7] == operand[7]) && (sum[7] != work[7]);
        flags[ST_NEG_BIT]           = sum[7];
        flag_mask                   = 5'h1f;
      end
      OP_MOVF: begin
        flags[ST_ZERO_BIT] = (operand == 8'h00);
        flags[ST_NEG_BIT]  = operand[7];
        flag_mask          = 5'h14;
      end
      OP_MOVWF: result = work;
      OP_CLRF: begin
        result             = 8'h00;
        flags[ST_ZERO_BIT] = 1'b1;
        flag_mask          = 5'h04;
      end
      OP_SETF: result = BYTE_ALL;
      OP_BSF:  result = operand | bmask;
      OP_BCF:  result = operand & ~bmask;
      default: result = operand;
    endcase
  end

endmodule : ilo_alu

// ==== test/ilo_core_asserts.sv ====
// Checker for the indexed literal offset decoder, bound to its top.
// Assumes one clock, reset high, and that config writes never share an instruction.
`timescale 1ns/1ps
module ilo_core_asserts
  import ilo_pkg::*;
(
  input wire logic           clk_sys,
  input wire logic           rst,
  input wire logic [RAW-1:0] reg_addr,
  input wire logic [RDW-1:0] reg_wdata,
  input wire logic           reg_wr,
  input wire logic           reg_rd,
  input wire logic [RDW-1:0] reg_rdata,
  input wire logic [MAW-1:0] mem_addr,
  input wire logic           mem_rd,
  input wire logic           mem_wr,
  input wire logic [7:0]     mem_wdata,
  input wire logic [7:0]     mem_rdata,
  input wire logic           busy
);
  // ----------------------------------------------------------------
  // Shadow of the addressing registers
  // ----------------------------------------------------------------
  logic           ext_ff, nxt_ext, take;
  logic [MAW-1:0] ptr_ff, nxt_ptr, exp_ff, nxt_exp;
  logic [3:0]     bank_ff, nxt_bank;
  logic [7:0]     fld;

  // Predicted address is frozen at acceptance, as the core latches it early
  always_comb begin
    take = reg_wr && !busy && (reg_addr == REG_INSTR);
    fld = reg_wdata[7:0];
    nxt_ext = (reg_wr && reg_addr == REG_CTRL) ? reg_wdata[CTRL_EXT_BIT] : ext_ff;
    nxt_ptr = (reg_wr && reg_addr == REG_PTR2) ? reg_wdata[MAW-1:0] : ptr_ff;
    nxt_bank = (reg_wr && reg_addr == REG_BANK) ? reg_wdata[3:0] : bank_ff;
    nxt_exp = exp_ff;
    if (take && ext_ff && !reg_wdata[IN_ACCESS_BIT] && fld <= ACCESS_LIMIT) nxt_exp = ptr_ff + {4'h0, fld};
    else if (take && reg_wdata[IN_ACCESS_BIT]) nxt_exp = {bank_ff, fld};
    else if (take) nxt_exp = {(fld <= ACCESS_LIMIT) ? ACCESS_LO_PAGE : ACCESS_HI_PAGE, fld};
  end

  // Shadow registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_ff <= 1'b0;
      ptr_ff <= '0;
      bank_ff <= 4'h0;
      exp_ff <= '0;
    end else begin
      ext_ff <= nxt_ext;
      ptr_ff <= nxt_ptr;
      bank_ff <= nxt_bank;
      exp_ff <= nxt_exp;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Decode, read, process, write, then idle
  sequence seq_phases;
    busy && !mem_rd ##1 busy && mem_rd ##1 busy && !mem_rd ##1 busy && !mem_rd ##1 !busy;
  endsequence

  chk_phase_order: assert property (take |=> seq_phases)
    else $error("instruction phases out of order");
  chk_read_addr: assert property (take |-> ##2 mem_rd && mem_addr == exp_ff)
    else $error("effective address wrong in read phase");
  chk_zero_ptr: assert property (take && ext_ff && ptr_ff == '0 && !reg_wdata[IN_ACCESS_BIT]
    && fld <= ACCESS_LIMIT |-> ##2 mem_addr < 12'h060)
    else $error("zero pointer left the access area");
  chk_wr_slot: assert property (mem_wr |-> $past(mem_rd, 2) && busy)
    else $error("memory write outside write phase");
  chk_addr_hold: assert property (mem_wr |-> $stable(mem_addr))
    else $error("address moved before write");
  chk_strobe_excl: assert property (!(mem_rd && mem_wr))
    else $error("read and write strobes together");
  chk_idle_quiet: assert property (!busy |-> !mem_rd && !mem_wr)
    else $error("memory strobe while idle");
  chk_rdata_slot: assert property (reg_rdata != '0 |-> $past(reg_rd))
    else $error("read data outside its slot");
endmodule : ilo_core_asserts

bind ilo_core ilo_core_asserts i_ilo_core_asserts (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .busy);

// ==== test/ilo_core_tb.sv ====
// Self-checking bench for the indexed literal offset decoder.
// Assumes the bench plays data memory answering one cycle after a read.
`timescale 1ns/1ps
module ilo_core_tb;
  import ilo_pkg::*;
  logic           clk_sys = 1'b0;
  logic           rst = 1'b1;
  logic [RAW-1:0] reg_addr = '0;
  logic [RDW-1:0] reg_wdata = '0;
  logic           reg_wr = 1'b0;
  logic           reg_rd = 1'b0;
  logic [RDW-1:0] reg_rdata;
  logic [MAW-1:0] mem_addr, seen_ad;
  logic           mem_rd, mem_wr, busy;
  logic [7:0]     mem_wdata, seen_wd;
  logic [7:0]     mem_rdata = 8'h00;
  logic [7:0]     mem [0:4095];
  logic [15:0]    d;
  int             mismatches, check_count, rd_cnt, wr_cnt, cyc, r0, w0;
  typedef struct packed {
    logic ext; logic [11:0] ptr; logic [7:0] w; logic [15:0] op; logic [7:0] m;
    logic [11:0] ea; logic ix; logic wr; logic [7:0] val; logic [7:0] st;
  } ilo_row_t;
  ilo_row_t rows [15];
  ilo_row_t r;

  ilo_core i_ilo_core (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .busy(busy));

  // ----------------------------------------------------------------
  // Clock, memory stand-in and hang guard
  // ----------------------------------------------------------------
  always #4 clk_sys = ~clk_sys;

  // Read data toggles outside its slot so a late sample cannot pass
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (mem_rd) begin
      mem_rdata <= mem[mem_addr];
      seen_ad <= mem_addr;
      rd_cnt <= rd_cnt + 1;
    end else
      mem_rdata <= ~mem_rdata;
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
      seen_wd <= mem_wdata;
      wr_cnt <= wr_cnt + 1;
    end
    if (cyc == 3000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [RAW-1:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [RAW-1:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic wait_idle;
    int i;
    i = 0;
    @(posedge clk_sys);
    while (busy !== 1'b0 && i < 20) begin
      @(posedge clk_sys);
      i++;
    end
    if (i >= 20) mismatches++;
  endtask : wait_idle

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    // ext ptr w op m ea ix wr val st; bank fixed at 3
    rows = '{'{1, 12'ha00, 8'h17, 16'h242c, 8'h20, 12'ha2c, 1, 0, 8'h37, 8'h00},
      '{1, 12'ha00, 8'h17, 16'h262c, 8'h20, 12'ha2c, 1, 1, 8'h37, 8'h00},
      '{1, 12'ha00, 8'h80, 16'h245f, 8'h80, 12'ha5f, 1, 0, 8'h00, 8'h0d},
      '{1, 12'ha00, 8'h0f, 16'h2460, 8'h01, 12'hf60, 0, 0, 8'h10, 8'h02},
      '{0, 12'ha00, 8'h7f, 16'h242c, 8'h01, 12'h02c, 0, 0, 8'h80, 8'h1a},
      '{0, 12'ha00, 8'h17, 16'h252c, 8'h20, 12'h32c, 0, 0, 8'h37, 8'h00},
      '{1, 12'ha00, 8'h17, 16'h252c, 8'h20, 12'h32c, 0, 0, 8'h37, 8'h00},
      '{1, 12'h000, 8'h17, 16'h242c, 8'h20, 12'h02c, 1, 0, 8'h37, 8'h00},
      '{1, 12'hfff, 8'h17, 16'h245f, 8'h20, 12'h05e, 1, 0, 8'h37, 8'h00},
      '{1, 12'ha00, 8'h17, 16'h8e0a, 8'h55, 12'ha0a, 1, 1, 8'hd5, 8'h00},
      '{1, 12'ha00, 8'h17, 16'h900a, 8'hff, 12'ha0a, 1, 1, 8'hfe, 8'h00},
      '{1, 12'ha00, 8'h17, 16'h680a, 8'h55, 12'ha0a, 1, 1, 8'hff, 8'h00},
      '{1, 12'ha00, 8'h17, 16'h6a0a, 8'h55, 12'ha0a, 1, 1, 8'h00, 8'h00},
      '{1, 12'ha00, 8'h17, 16'h6e0a, 8'h55, 12'ha0a, 1, 1, 8'h17, 8'h00},
      '{1, 12'ha00, 8'h17, 16'h500a, 8'h55, 12'ha0a, 1, 0, 8'h55, 8'h00}};
    foreach (mem[k]) mem[k] = 8'ha5;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    wr(REG_BANK, 16'h0003);
    // Table of operand forms, one instruction per row
    foreach (rows[n]) begin
      r = rows[n];
      wr(REG_CTRL, {15'h0, r.ext});
      wr(REG_PTR2, {4'h0, r.ptr});
      wr(REG_WORK, {8'h0, r.w});
      mem[r.ea] = r.m;
      w0 = wr_cnt;
      wr(REG_INSTR, r.op);
      wait_idle();
      check(16'(wr_cnt - w0), {15'h0, r.wr});
      check({4'h0, seen_ad}, {4'h0, r.ea});
      rd(REG_EADDR, d);
      check(d, {r.ix, 3'h0, r.ea});
      if (r.wr) check({8'h0, seen_wd}, {8'h0, r.val});
      else begin
        rd(REG_WORK, d);
        check(d, {8'h0, r.val});
      end
      if (r.op[15:10] == OPC_ADD_WORKING_TO_FILE) begin
        rd(REG_STATUS, d);
        check(d & 16'h001f, {8'h0, r.st});
      end
    end
    // Request while busy is dropped, only one read phase happens
    r0 = rd_cnt;
    w0 = wr_cnt;
    wr(REG_INSTR, 16'h242c);
    wr(REG_INSTR, 16'h262c);
    wait_idle();
    check(16'(rd_cnt - r0), 16'h0001);
    check(16'(wr_cnt - w0), 16'h0000);
    rd(REG_INSTR, d);
    check(d, 16'h242c);
    // Unsupported opcode flags itself and touches nothing
    wr(REG_INSTR, 16'h0000);
    wait_idle();
    check(16'(wr_cnt - w0), 16'h0000);
    rd(REG_STATUS, d);
    check(d & 16'h0040, 16'h0040);
    // Software clear of status, then read back the settings left in place
    wr(REG_STATUS, 16'h0000);
    rd(REG_STATUS, d);
    check(d, 16'h0000);
    rd(REG_PTR2, d);
    check(d, 16'h0a00);
    rd(REG_BANK, d);
    check(d, 16'h0003);
    rd(REG_CTRL, d);
    check(d, 16'h0001);
    // Second reset mid-run clears every register; unmapped reads zero
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 0; a < 7; a++) begin
      rd(a[RAW-1:0], d);
      check(d, 16'h0000);
    end
    rd(4'hf, d);
    check(d, 16'h0000);
    print_verdict();
  end
endmodule : ilo_core_tb
